// File: hdl/fsu_core.sv
// Flash security interlock: flash array, lock state, unlock paths and TAP
`timescale 1ns/1ps
module fsu_core (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [7:0] bs_pin_in,
	output logic [7:0] bs_pin_out,
	output logic bs_extest,
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic cpu_key,
	input wire logic [14:0] cpu_addr,
	input wire logic [15:0] cpu_wdata,
	output logic [15:0] cpu_rdata,
	output logic cpu_ack,
	output logic secured,
	output logic debug_enable,
	output logic recovery_busy
);
	typedef struct packed {
		fsu_pkg::fsu_core_type st;
		logic sec;
		logic bd_ok;
		logic [1:0] key_idx;
		logic key_match;
		logic [6:0] div;
		logic [6:0] cnt;
		logic [14:0] ea;
		logic go_s1;
		logic go_s2;
		logic go_seen;
		logic dbg_s1;
		logic dbg_s2;
		logic dbg_seen;
		logic ack_t;
		logic [15:0] dbg_word;
		logic [15:0] rdata;
		logic ack;
		logic dbg_en;
	} fsu_core_state_type;
	fsu_core_state_type s_q, s_d;

	// Flash array; not reset, so contents persist across every reset
	logic [15:0] mem [0:fsu_pkg::FLASH_WORDS-1];
	logic mem_we;
	logic [14:0] mem_wa;
	logic [15:0] mem_wd;
	logic [14:0] key_a;
	logic go_t;
	logic dbg_t;
	logic [6:0] tap_div;
	logic [14:0] tap_addr;
	logic locked;

	fsu_tap u_tap (
		.tck(tck),
		.rstn(rstn),
		.tms(tms),
		.tdi(tdi),
		.tdo(tdo),
		.tdo_oe(tdo_oe),
		.bs_pin_in(bs_pin_in),
		.bs_pin_out(bs_pin_out),
		.bs_extest(bs_extest),
		.go_t(go_t),
		.div(tap_div),
		.dbg_t(dbg_t),
		.dbg_addr(tap_addr),
		.ack_t(s_q.ack_t),
		.dbg_word(s_q.dbg_word),
		.busy(recovery_busy)
	);

	// Debug is locked while evaluating, while erasing, or while secured without a back-door unlock
	assign locked = (s_q.st != fsu_pkg::RUN) || (s_q.sec && !s_q.bd_ok);
	assign key_a = fsu_pkg::KEY_ADDR + {13'h0, s_q.key_idx};

	// Lock state, cpu access, key check, erase walk and debug service
	always_comb begin
		s_d = s_q;
		mem_we = 1'b0;
		mem_wa = cpu_addr;
		mem_wd = 16'h0;
		s_d.ack = 1'b0;
		s_d.go_s1 = go_t;
		s_d.go_s2 = s_q.go_s1;
		s_d.dbg_s1 = dbg_t;
		s_d.dbg_s2 = s_q.dbg_s1;
		unique case (s_q.st)
			fsu_pkg::EVAL: begin
				// Security follows the stored word, read once after reset
				s_d.sec = (mem[fsu_pkg::SEC_ADDR] == fsu_pkg::SEC_ON);
				s_d.st = fsu_pkg::RUN;
			end
			fsu_pkg::RUN: begin
				if (cpu_req) begin
					s_d.ack = 1'b1;
					s_d.rdata = mem[cpu_addr];
					if (cpu_key) begin
						// Key words are checked in order against the top words
						s_d.key_match = s_q.key_match && (cpu_wdata == mem[key_a]);
						s_d.key_idx = s_q.key_idx + 2'h1;
						if (s_q.key_idx == fsu_pkg::KEY_LAST) begin
							s_d.bd_ok = s_q.bd_ok || s_d.key_match;
							s_d.key_match = 1'b1;
						end
					end else begin
						// Any other flash access breaks the key sequence
						s_d.key_idx = 2'h0;
						s_d.key_match = 1'b1;
						if (cpu_we) begin
							mem_we = 1'b1;
							mem_wd = mem[cpu_addr] & cpu_wdata;
						end
					end
				end
			end
			fsu_pkg::ERASE: begin
				// One word erased every div+1 cycles, whole array
				if (s_q.cnt == s_q.div) begin
					s_d.cnt = 7'h0;
					mem_we = 1'b1;
					mem_wa = s_q.ea;
					mem_wd = fsu_pkg::ERASED;
					s_d.ea = s_q.ea + 15'h1;
					if (s_q.ea == fsu_pkg::LAST_ADDR) begin
						s_d.st = fsu_pkg::RUN;
					end
				end else begin
					s_d.cnt = s_q.cnt + 7'h1;
				end
			end
			default: s_d.st = fsu_pkg::EVAL;
		endcase
		// Recovery start from the TAP; divider is held stable by the host
		if (s_q.go_s2 != s_q.go_seen) begin
			s_d.go_seen = s_q.go_s2;
			if (s_q.st != fsu_pkg::EVAL) begin
				s_d.st = fsu_pkg::ERASE;
				s_d.div = tap_div;
				s_d.cnt = 7'h0;
				s_d.ea = 15'h0;
				s_d.ack = 1'b0;
				mem_we = 1'b0;
			end
		end
		// Debug read: answer zero when locked, flash word otherwise
		if (s_q.dbg_s2 != s_q.dbg_seen) begin
			s_d.dbg_seen = s_q.dbg_s2;
			s_d.ack_t = ~s_q.ack_t;
			s_d.dbg_word = locked ? 16'h0 : mem[tap_addr];
		end
		s_d.dbg_en = !locked;
	end

	// Flash array write port
	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// State register; reset leaves the device locked until evaluated
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{st: fsu_pkg::EVAL, sec: 1'b1, key_match: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign cpu_rdata = s_q.rdata;
	assign cpu_ack = s_q.ack;
	assign secured = s_q.sec;
	assign debug_enable = s_q.dbg_en;
	assign recovery_busy = (s_q.st == fsu_pkg::ERASE);
endmodule

// File: hdl/fsu_pkg.sv
// Constants and types shared by the flash security interlock
package fsu_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 16;
	localparam int FLASH_WORDS = 32768;
	localparam int DIV_W = 7;
	localparam int IR_W = 4;
	localparam int BSR_W = 8;
	localparam int DR_W = 32;
	// Security word location and its values
	localparam logic [14:0] SEC_ADDR = 15'h7ff7;
	localparam logic [15:0] SEC_ON = 16'h0002;
	localparam logic [15:0] SEC_OFF = 16'h0000;
	localparam logic [15:0] ERASED = 16'hffff;
	// Back-door key words sit at the top four flash words
	localparam logic [14:0] KEY_ADDR = 15'h7ffc;
	localparam logic [14:0] LAST_ADDR = 15'h7fff;
	localparam logic [1:0] KEY_LAST = 2'h3;
	// TAP instruction codes
	localparam logic [3:0] IR_EXTEST = 4'h0;
	localparam logic [3:0] IR_SAMPLE = 4'h1;
	localparam logic [3:0] IR_IDCODE = 4'h2;
	localparam logic [3:0] IR_DEBUG = 4'h7;
	localparam logic [3:0] IR_RECOVER = 4'h8;
	localparam logic [3:0] IR_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	// TAP controller states
	typedef enum logic [15:0] {
		TLR = 16'h0001, RTI = 16'h0002, SELDR = 16'h0004, CAPDR = 16'h0008,
		SHDR = 16'h0010, EX1DR = 16'h0020, PADR = 16'h0040, EX2DR = 16'h0080,
		UPDR = 16'h0100, SELIR = 16'h0200, CAPIR = 16'h0400, SHIR = 16'h0800,
		EX1IR = 16'h1000, PAIR = 16'h2000, EX2IR = 16'h4000, UPIR = 16'h8000
	} fsu_tap_type;
	// Flash side states
	typedef enum logic [2:0] {
		EVAL = 3'h1, RUN = 3'h2, ERASE = 3'h4
	} fsu_core_type;
endpackage

// File: hdl/fsu_tap.sv
// JTAG TAP controller with boundary scan, ID, debug and recovery registers
`timescale 1ns/1ps
module fsu_tap #(
	parameter logic [31:0] ID_VALUE = 32'h0a5a_5001 // Arbitrary identification value
) (
	input wire logic tck,
	input wire logic rstn,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [7:0] bs_pin_in,
	output logic [7:0] bs_pin_out,
	output logic bs_extest,
	output logic go_t,
	output logic [6:0] div,
	output logic dbg_t,
	output logic [14:0] dbg_addr,
	input wire logic ack_t,
	input wire logic [15:0] dbg_word,
	input wire logic busy
);
	typedef struct packed {
		fsu_pkg::fsu_tap_type st;
		logic [3:0] ir;
		logic [3:0] ir_sh;
		logic [31:0] dr_sh;
		logic [6:0] div;
		logic [7:0] bsr;
		logic [7:0] bs_s1;
		logic [7:0] bs_s2;
		logic go_t;
		logic dbg_t;
		logic [14:0] addr;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
		logic [15:0] word;
		logic busy_s1;
		logic busy_s2;
		logic tdo;
		logic tdo_oe;
	} fsu_tap_state_type;
	fsu_tap_state_type s_q, s_d;

	// TAP walk, register capture, shift and update
	always_comb begin
		s_d = s_q;
		s_d.bs_s1 = bs_pin_in;
		s_d.bs_s2 = s_q.bs_s1;
		s_d.ack_s1 = ack_t;
		s_d.ack_s2 = s_q.ack_s1;
		s_d.busy_s1 = busy;
		s_d.busy_s2 = s_q.busy_s1;
		// Returned debug word is taken once its toggle has crossed
		if (s_q.ack_s2 != s_q.ack_seen) begin
			s_d.ack_seen = s_q.ack_s2;
			s_d.word = dbg_word;
		end
		unique case (s_q.st)
			fsu_pkg::TLR: s_d.st = tms ? fsu_pkg::TLR : fsu_pkg::RTI;
			fsu_pkg::RTI: s_d.st = tms ? fsu_pkg::SELDR : fsu_pkg::RTI;
			fsu_pkg::SELDR: s_d.st = tms ? fsu_pkg::SELIR : fsu_pkg::CAPDR;
			fsu_pkg::CAPDR: s_d.st = tms ? fsu_pkg::EX1DR : fsu_pkg::SHDR;
			fsu_pkg::SHDR: s_d.st = tms ? fsu_pkg::EX1DR : fsu_pkg::SHDR;
			fsu_pkg::EX1DR: s_d.st = tms ? fsu_pkg::UPDR : fsu_pkg::PADR;
			fsu_pkg::PADR: s_d.st = tms ? fsu_pkg::EX2DR : fsu_pkg::PADR;
			fsu_pkg::EX2DR: s_d.st = tms ? fsu_pkg::UPDR : fsu_pkg::SHDR;
			fsu_pkg::UPDR: s_d.st = tms ? fsu_pkg::SELDR : fsu_pkg::RTI;
			fsu_pkg::SELIR: s_d.st = tms ? fsu_pkg::TLR : fsu_pkg::CAPIR;
			fsu_pkg::CAPIR: s_d.st = tms ? fsu_pkg::EX1IR : fsu_pkg::SHIR;
			fsu_pkg::SHIR: s_d.st = tms ? fsu_pkg::EX1IR : fsu_pkg::SHIR;
			fsu_pkg::EX1IR: s_d.st = tms ? fsu_pkg::UPIR : fsu_pkg::PAIR;
			fsu_pkg::PAIR: s_d.st = tms ? fsu_pkg::EX2IR : fsu_pkg::PAIR;
			fsu_pkg::EX2IR: s_d.st = tms ? fsu_pkg::UPIR : fsu_pkg::SHIR;
			fsu_pkg::UPIR: s_d.st = tms ? fsu_pkg::SELDR : fsu_pkg::RTI;
			default: s_d.st = fsu_pkg::TLR;
		endcase
		// ID and boundary scan stay usable whether secured or not
		unique case (s_q.st)
			fsu_pkg::TLR: s_d.ir = fsu_pkg::IR_IDCODE;
			fsu_pkg::CAPIR: s_d.ir_sh = fsu_pkg::IR_CAPTURE;
			fsu_pkg::SHIR: s_d.ir_sh = {tdi, s_q.ir_sh[3:1]};
			fsu_pkg::UPIR: s_d.ir = s_q.ir_sh;
			fsu_pkg::CAPDR: begin
				unique case (s_q.ir)
					fsu_pkg::IR_IDCODE: s_d.dr_sh = ID_VALUE;
					fsu_pkg::IR_EXTEST, fsu_pkg::IR_SAMPLE: s_d.dr_sh = {24'h0, s_q.bs_s2};
					fsu_pkg::IR_DEBUG: s_d.dr_sh = {16'h0, s_q.word};
					fsu_pkg::IR_RECOVER: s_d.dr_sh = {31'h0, s_q.busy_s2};
					default: s_d.dr_sh = 32'h0;
				endcase
			end
			fsu_pkg::SHDR: s_d.dr_sh = {tdi, s_q.dr_sh[31:1]};
			fsu_pkg::UPDR: begin
				unique case (s_q.ir)
					fsu_pkg::IR_EXTEST, fsu_pkg::IR_SAMPLE: s_d.bsr = s_q.dr_sh[31:24];
					fsu_pkg::IR_RECOVER: s_d.div = s_q.dr_sh[31:25];
					fsu_pkg::IR_DEBUG: begin
						s_d.addr = s_q.dr_sh[31:17];
						s_d.dbg_t = ~s_q.dbg_t;
					end
					default: s_d.bsr = s_q.bsr;
				endcase
			end
			default: s_d.ir_sh = s_q.ir_sh;
		endcase
		// Erase starts only on entry into Run-Test/Idle
		if (s_d.st == fsu_pkg::RTI && s_q.st != fsu_pkg::RTI &&
				s_q.ir == fsu_pkg::IR_RECOVER) begin
			s_d.go_t = ~s_q.go_t;
		end
		// Serial output follows the register being shifted
		s_d.tdo_oe = (s_d.st == fsu_pkg::SHDR) || (s_d.st == fsu_pkg::SHIR);
		s_d.tdo = (s_d.st == fsu_pkg::SHIR) ? s_d.ir_sh[0] : s_d.dr_sh[0];
		if (s_q.ir == fsu_pkg::IR_BYPASS && s_q.st == fsu_pkg::SHDR) begin
			s_d.dr_sh = {31'h0, tdi};
		end
	end

	// State register, cleared by device reset
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{st: fsu_pkg::TLR, ir: fsu_pkg::IR_IDCODE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign tdo = s_q.tdo;
	assign tdo_oe = s_q.tdo_oe;
	assign bs_pin_out = s_q.bsr;
	assign bs_extest = (s_q.ir == fsu_pkg::IR_EXTEST);
	assign go_t = s_q.go_t;
	assign div = s_q.div;
	assign dbg_t = s_q.dbg_t;
	assign dbg_addr = s_q.addr;
endmodule

// File: tb/fsu_chk.sv
// Port checks for the flash security interlock
`timescale 1ns/1ps
module fsu_chk (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic cpu_req,
	input wire logic cpu_key,
	input wire logic cpu_ack,
	input wire logic [15:0] cpu_rdata,
	input wire logic secured,
	input wire logic debug_enable,
	input wire logic recovery_busy
);
	logic [1:0] cnt_q;
	// Edges since reset release, saturating at three
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) cnt_q <= 2'h0;
		else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	a_ack_cause: assert property (cpu_ack |-> $past(cpu_req))
		else $error("ack without a request");
	a_eval_refuse: assert property (cnt_q < 2'h2 |-> !cpu_ack)
		else $error("access taken during evaluation");
	a_busy_refuse: assert property (recovery_busy && $past(recovery_busy) |-> !cpu_ack)
		else $error("access taken during erase");
	a_run_accept: assert property (cpu_req && cnt_q == 2'h3 && !recovery_busy |=> cpu_ack)
		else $error("access not answered");
	a_sec_stable: assert property (cnt_q == 2'h3 |-> $stable(secured))
		else $error("secured changed without reset");
	a_key_unlock: assert property ($rose(debug_enable) && secured |-> $past(cpu_key, 2))
		else $error("unlock without key access");
	a_busy_min: assert property ($rose(recovery_busy) |=> recovery_busy [*8])
		else $error("erase ended too early");
	a_rdata_hold: assert property (!cpu_ack |-> $stable(cpu_rdata))
		else $error("read data moved without ack");
endmodule

// File: tb/fsu_host.sv
// Behavioural JTAG host driving the TAP pins
`timescale 1ns/1ps
module fsu_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// Pins start quiet; the test clock only runs inside tasks
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One 30 ns test clock; pins change while tck is low
	task automatic tick(input logic m, input logic d);
		tms = m;
		tdi = d;
		#15 tck = 1'b1;
		#15 tck = 1'b0;
	endtask
	// Scan n bits LSB first via IR or DR, ending in Run-Test/Idle
	task automatic scan(input logic ir, input int n, input logic [31:0] v, output logic [31:0] q);
		q = 32'h0;
		tick(1'b0, ~tdi);
		tick(1'b1, ~tdi);
		if (ir) tick(1'b1, ~tdi);
		tick(1'b0, ~tdi);
		tick(1'b0, ~tdi);
		for (int i = 0; i < n; i++) begin
			q[i] = tdo;
			tick(i == n - 1, v[i]);
		end
		tick(1'b1, ~tdi);
		tick(1'b0, ~tdi);
	endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the flash security interlock
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
	total_checks++; \
	if ((s) !== (e)) begin \
		err_count++; \
		$display("unexpected %s exp %h got %h", n, e, s); \
	end \
end
module tb;
	localparam logic [31:0] ID = 32'h0a5a_5001; // Identification value set by the design
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic cpu_req = 1'b0, cpu_we = 1'b0, cpu_key = 1'b0;
	logic [14:0] cpu_addr = 15'h0;
	logic [15:0] cpu_wdata = 16'h0;
	logic [15:0] cpu_rdata, rd;
	logic [31:0] q;
	logic cpu_ack, secured, debug_enable, recovery_busy, tck, tms, tdi, tdo, tdo_oe, bs_extest;
	logic [7:0] bs_pin_in = 8'h00;
	logic [7:0] bs_pin_out;
	int err_count = 0, total_checks = 0, cyc = 0;
	// Core clock and run ceiling
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 80000) begin // Two full erases plus scans fit well below this
			err_count++;
			final_report();
		end
	end
	fsu_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	fsu_core uut (.ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .bs_pin_in(bs_pin_in), .bs_pin_out(bs_pin_out),
		.bs_extest(bs_extest), .cpu_req(cpu_req),
		.cpu_we(cpu_we), .cpu_key(cpu_key), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .secured(secured),
		.debug_enable(debug_enable), .recovery_busy(recovery_busy));
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Device reset; low rstn also resets the TAP, so the test clocks given meanwhile change nothing
	task automatic rst();
		rstn = 1'b0;
		host.tick(1'b1, ~tdi);
		host.tick(1'b1, ~tdi);
		repeat (10) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (3) @(negedge ref_clk);
	endtask
	// One flash access; answer taken in the ack cycle
	task automatic acc(input logic we, input logic key, input logic [14:0] a, input logic [15:0] wd);
		@(negedge ref_clk);
		cpu_req = 1'b1;
		cpu_we = we;
		cpu_key = key;
		cpu_addr = a;
		cpu_wdata = wd;
		@(negedge ref_clk);
		`CHK("cpu_ack", 1'b1, cpu_ack)
		rd = cpu_rdata;
		cpu_req = 1'b0;
	endtask
	// Debug read: address scan, then a second scan captures the word
	task automatic dbg(input logic [14:0] a);
		host.scan(1'b1, 4, {28'h0, fsu_pkg::IR_DEBUG}, q);
		host.scan(1'b0, 16, {16'h0, a, 1'b0}, q); // Address sits in bits 15 to 1
		repeat (4) @(negedge ref_clk);
		host.scan(1'b0, 16, {16'h0, a, 1'b0}, q);
	endtask
	// Mass erase over JTAG; core requests are refused while it runs
	task automatic mass_erase();
		int n;
		host.scan(1'b1, 4, {28'h0, fsu_pkg::IR_RECOVER}, q);
		`CHK("ir_capture", 4'h1, q[3:0])
		host.scan(1'b0, 7, 32'h0, q);
		repeat (8) @(negedge ref_clk);
		`CHK("busy", 1'b1, recovery_busy)
		cpu_req = 1'b1;
		@(negedge ref_clk);
		`CHK("cpu_ack", 1'b0, cpu_ack)
		cpu_req = 1'b0;
		for (n = 0; n < 40000 && recovery_busy === 1'b1; n++) @(negedge ref_clk);
		`CHK("erase_len", 1'b1, n > 32000)
		`CHK("busy", 1'b0, recovery_busy)
	endtask
	// Recovery of a secured device, then reset to run unsecured
	task automatic t_recover();
		mass_erase();
		`CHK("secured", 1'b1, secured)
		rst();
		`CHK("secured", 1'b0, secured)
		acc(1'b0, 1'b0, fsu_pkg::SEC_ADDR, 16'h0);
		`CHK("sec_word", fsu_pkg::ERASED, rd)
	endtask
	// Programming clears bits only; securing value locks after reset
	task automatic t_prog();
		acc(1'b1, 1'b0, 15'h0, 16'h00ff);
		acc(1'b1, 1'b0, 15'h0, 16'hff0f);
		acc(1'b0, 1'b0, 15'h0, 16'h0);
		`CHK("word0", 16'h000f, rd)
		acc(1'b1, 1'b0, fsu_pkg::SEC_ADDR, fsu_pkg::SEC_ON);
		`CHK("secured", 1'b0, secured)
		rst();
		`CHK("secured", 1'b1, secured)
		rst();
		`CHK("secured", 1'b1, secured)
		`CHK("debug_enable", 1'b0, debug_enable)
		acc(1'b0, 1'b0, 15'h0, 16'h0);
		`CHK("word0", 16'h000f, rd)
	endtask
	// Secured: ID still readable, debug reads blocked
	task automatic t_jtag();
		bs_pin_in = 8'h5a;
		host.scan(1'b1, 4, {28'h0, fsu_pkg::IR_SAMPLE}, q);
		host.scan(1'b0, 8, 32'h0000_00c3, q);
		`CHK("bs_capture", 8'h5a, q[7:0])
		`CHK("bs_pin_out", 8'hc3, bs_pin_out)
		`CHK("bs_extest", 1'b0, bs_extest)
		`CHK("tdo_oe", 1'b0, tdo_oe)
		host.scan(1'b1, 4, {28'h0, fsu_pkg::IR_EXTEST}, q);
		`CHK("bs_extest", 1'b1, bs_extest)
		host.scan(1'b1, 4, {28'h0, fsu_pkg::IR_IDCODE}, q);
		host.scan(1'b0, 32, 32'h0, q);
		`CHK("idcode", ID, q)
		dbg(fsu_pkg::SEC_ADDR);
		`CHK("dbg_word", 16'h0, q[15:0])
	endtask
	// Broken key sequence fails, whole key unlocks until reset
	task automatic t_key();
		for (int i = 0; i < 4; i++) acc(1'b1, 1'b0, fsu_pkg::KEY_ADDR + 15'(i), 16'h1230 + 16'(i));
		for (int i = 0; i < 3; i++) acc(1'b0, 1'b1, fsu_pkg::KEY_ADDR + 15'(i), 16'h1230 + 16'(i));
		acc(1'b0, 1'b0, 15'h0, 16'h0);
		acc(1'b0, 1'b1, fsu_pkg::LAST_ADDR, 16'h1233);
		repeat (3) @(negedge ref_clk);
		`CHK("debug_enable", 1'b0, debug_enable)
		acc(1'b0, 1'b0, 15'h0, 16'h0); // Clears the key count left by the stray key word
		for (int i = 0; i < 4; i++) acc(1'b0, 1'b1, fsu_pkg::KEY_ADDR + 15'(i), 16'h1230 + 16'(i));
		repeat (3) @(negedge ref_clk);
		`CHK("debug_enable", 1'b1, debug_enable)
		dbg(fsu_pkg::SEC_ADDR);
		`CHK("dbg_word", fsu_pkg::SEC_ON, q[15:0])
		rst();
		`CHK("debug_enable", 1'b0, debug_enable)
	endtask
	// Secure again, then a zero security word unsecures after reset
	task automatic t_unsec();
		acc(1'b1, 1'b0, fsu_pkg::SEC_ADDR, fsu_pkg::SEC_ON);
		rst();
		`CHK("secured", 1'b1, secured)
		acc(1'b1, 1'b0, fsu_pkg::SEC_ADDR, fsu_pkg::SEC_OFF);
		rst();
		`CHK("secured", 1'b0, secured)
		`CHK("debug_enable", 1'b1, debug_enable)
	endtask
	// Main sequence
	initial begin
		rst();
		mass_erase(); // Flash starts unknown, so clear it first
		rst();
		t_prog();
		t_jtag();
		t_key();
		t_recover();
		t_unsec();
		final_report();
	end
endmodule
bind fsu_core fsu_chk chk (.ref_clk(ref_clk), .rstn(rstn), .cpu_req(cpu_req), .cpu_key(cpu_key),
	.cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .secured(secured), .debug_enable(debug_enable),
	.recovery_busy(recovery_busy));
